// File: rtl/pdb_pkg.sv
package pdb_pkg;
    // clock and timing
    localparam int CLK_HZ     = 20_000_000;
    localparam int MINUTE_S   = 60;
    localparam int MINUTE_CYC = MINUTE_S * CLK_HZ;
    localparam int REPORT_S   = 10;
    localparam int REPORT_CYC = REPORT_S * CLK_HZ;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FACTOR = 8'h04;
    localparam logic [7:0] ADDR_BASE   = 8'h08;
    localparam logic [7:0] ADDR_EFFDLY = 8'h0c;
    localparam logic [7:0] ADDR_MANUAL = 8'h10;
    localparam logic [7:0] ADDR_DISABL = 8'h14;
    localparam logic [7:0] ADDR_ELAPSD = 8'h18;
    localparam logic [7:0] ADDR_CYCLE  = 8'h1c;
    localparam logic [7:0] ADDR_LEVELS = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    // control and levels field positions
    localparam int CTRL_EXT   = 0;
    localparam int CTRL_DISCR = 1;
    localparam int CTRL_TEXT  = 2;
    localparam int CTRL_DPOL  = 3;
    localparam int CTRL_ELEN  = 4;
    localparam int CTRL_INDEP = 5;
    localparam int CTRL_ELACT = 6;
    localparam int CTRL_FON   = 8;
    localparam int CTRL_FOFF  = 10;
    localparam int LVL_ONVAL  = 0;
    localparam int LVL_OFFVAL = 8;
    localparam int LVL_DIMUP  = 16;
    localparam int LVL_DIMDN  = 20;
    // reset values and counter maximum
    localparam logic [11:0] CTRL_RST   = 12'h000;
    localparam logic [7:0]  FACTOR_RST = 8'h01;
    localparam logic [15:0] BASE_RST   = 16'h0001;
    localparam logic [7:0]  CYCLE_RST  = 8'h01;
    localparam logic [23:0] LEVELS_RST = 24'h19_00ff;
    localparam logic [15:0] ELAPSED_MAX = 16'hffff;
    // telegram objects, index doubles as push priority
    typedef enum logic [2:0] {
        OBJ_MOTION, OBJ_SWITCH, OBJ_DIM, OBJ_VALUE, OBJ_ELAPSED
    } pdb_obj_type;
    typedef enum logic [1:0] {FMT_SWITCH, FMT_DIM, FMT_VALUE} pdb_fmt_type;
    typedef enum {LC_OFF, LC_ON} pdb_lc_type;
    typedef struct packed {
        pdb_obj_type obj;
        logic [15:0] data;
    } pdb_tel_type;
    typedef struct packed {
        logic valid;
        logic value;
    } pdb_ext_type;
endpackage

// File: rtl/pdb_top.sv
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ns
// Contract
// - extension sends cyclic motion 1 to main unit, never a zero
// - effective extra delay equals received factor times base delay
// - factor input exists only when discrete and time extension enabled
// - manual 1 acts as detection start, manual 0 as detection end
// - manual control suspends automatic motion control
// - one-bit readable disable input with configurable polarity
// - two-byte counter of whole minutes since last motion
// - counter sent cyclically when active, else passive status only
// - counter is zero while motion or standard delay is active
// - counter saturates at maximum until new motion
// - counter present only when brightness independent and enabled
// - channel one drives a one-bit switching output
// - channel one drives a four-bit relative dimming output
// - channel one drives a one-byte absolute value output
// - switch and dim outputs may mix within one activation sequence
// - main unit takes external motion 1 as motion, ignores 0

// fifo with parameterised width and depth
module pdb_fifo #(
    parameter int W = 19,
    parameter int D = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    logic         wr_en;
    logic         rd_en;
    // full when pointers differ only in wrap bit
    assign in_ready  = !(wp_r[AW] != rp_r[AW] &&
                         wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem[rp_r[AW-1:0]];
    assign wr_en     = in_valid && in_ready;
    assign rd_en     = out_valid && out_ready;
    // storage
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
    // pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wr_en ? wp_r + 1'b1 : wp_r;
            rp_r <= rd_en ? rp_r + 1'b1 : rp_r;
        end
    end
endmodule

module pdb_top #(
    parameter int MINUTE_CYC = pdb_pkg::MINUTE_CYC,
    parameter int REPORT_CYC = pdb_pkg::REPORT_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                motion_det,
    input  wire logic                delay_run,
    input  wire pdb_pkg::pdb_ext_type ext_motion,
    output logic                     tx_valid,
    output pdb_pkg::pdb_tel_type     tx_tel,
    input  wire logic                tx_ready,
    output logic                     sw_out,
    output logic [3:0]               dim_out,
    output logic [7:0]               val_out,
    output logic                     light_on
);
    logic [11:0]          ctrl_r;
    logic [7:0]           factor_r;
    logic [15:0]          base_r;
    logic [23:0]          eff_dly_r;
    logic [7:0]           cycle_r;
    logic [23:0]          levels_r;
    logic                 dis_bit_r;
    logic                 man_act_r;
    logic                 man_val_r;
    logic                 man_wr_r;
    logic                 ext_pulse_r;
    logic [15:0]          elapsed_r;
    logic [30:0]          min_cnt_r;
    logic [30:0]          cyc_pre_r;
    logic [7:0]           cyc_min_r;
    logic [30:0]          rep_cnt_r;
    logic [4:0]           pend_r;
    logic [4:0]           pend_set;
    logic [4:0]           grant;
    pdb_pkg::pdb_lc_type  lc_state_r;
    pdb_pkg::pdb_tel_type push_tel;
    pdb_pkg::pdb_tel_type fifo_tel;
    pdb_pkg::pdb_fmt_type fmt;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 wr_en;
    logic                 fac_ok;
    logic                 dis;
    logic                 el_on;
    logic                 motion_any;
    logic                 min_tick;
    logic                 tgt;
    logic                 go_on;
    logic                 go_off;
    logic                 rep_fire;
    logic                 cyc_fire;
    logic [31:0]          rd_val;

    // address decode shared by read and write paths
    function automatic logic mapped(input logic [7:0] a);
        return a inside {pdb_pkg::ADDR_CTRL, pdb_pkg::ADDR_FACTOR,
                         pdb_pkg::ADDR_BASE, pdb_pkg::ADDR_EFFDLY,
                         pdb_pkg::ADDR_MANUAL, pdb_pkg::ADDR_DISABL,
                         pdb_pkg::ADDR_ELAPSD, pdb_pkg::ADDR_CYCLE,
                         pdb_pkg::ADDR_LEVELS, pdb_pkg::ADDR_STATUS};
    endfunction

    // derived control terms
    assign wr_en  = psel && penable && pready && pwrite && mapped(paddr);
    assign fac_ok = ctrl_r[pdb_pkg::CTRL_DISCR] &&
                    ctrl_r[pdb_pkg::CTRL_TEXT];
    assign dis    = dis_bit_r ^ ctrl_r[pdb_pkg::CTRL_DPOL];
    assign el_on  = ctrl_r[pdb_pkg::CTRL_ELEN] &&
                    ctrl_r[pdb_pkg::CTRL_INDEP];
    assign motion_any = motion_det || delay_run || ext_pulse_r;
    assign min_tick   = el_on && !motion_any &&
                        min_cnt_r == 31'(MINUTE_CYC - 1);

    // apb answer: ready one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped(paddr);
            prdata  <= (psel && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    // read mux, unused bits read as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            pdb_pkg::ADDR_CTRL:   rd_val[11:0] = ctrl_r;
            pdb_pkg::ADDR_FACTOR: rd_val[7:0]  = fac_ok ? factor_r : 8'h00;
            pdb_pkg::ADDR_BASE:   rd_val[15:0] = base_r;
            pdb_pkg::ADDR_EFFDLY: rd_val[23:0] = eff_dly_r;
            pdb_pkg::ADDR_MANUAL: rd_val[1:0]  = {man_val_r, man_act_r};
            pdb_pkg::ADDR_DISABL: rd_val[0]    = dis_bit_r;
            pdb_pkg::ADDR_ELAPSD: rd_val[15:0] = elapsed_r;
            pdb_pkg::ADDR_CYCLE:  rd_val[7:0]  = cycle_r;
            pdb_pkg::ADDR_LEVELS: rd_val[23:0] = levels_r;
            pdb_pkg::ADDR_STATUS: rd_val[3:0]  = {dis, motion_any,
                                    man_act_r, lc_state_r == pdb_pkg::LC_ON};
            default:              rd_val       = 32'h0000_0000;
        endcase
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= pdb_pkg::CTRL_RST;
            factor_r  <= pdb_pkg::FACTOR_RST;
            base_r    <= pdb_pkg::BASE_RST;
            cycle_r   <= pdb_pkg::CYCLE_RST;
            levels_r  <= pdb_pkg::LEVELS_RST;
            dis_bit_r <= 1'b0;
        end else if (wr_en) begin
            unique case (paddr)
                pdb_pkg::ADDR_CTRL:   ctrl_r   <= pwdata[11:0];
                pdb_pkg::ADDR_FACTOR: if (fac_ok) begin
                    factor_r <= pwdata[7:0];
                end
                pdb_pkg::ADDR_BASE:   base_r   <= pwdata[15:0];
                pdb_pkg::ADDR_DISABL: dis_bit_r <= pwdata[0];
                pdb_pkg::ADDR_CYCLE:  cycle_r  <= pwdata[7:0];
                pdb_pkg::ADDR_LEVELS: levels_r <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // effective extra delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_dly_r <= 24'h00_0000;
        end else begin
            eff_dly_r <= (fac_ok ? factor_r : 8'h01) * base_r;
        end
    end

    // manual override: bit0 value, bit1 releases back to automatic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_act_r <= 1'b0;
            man_val_r <= 1'b0;
            man_wr_r  <= 1'b0;
        end else begin
            man_wr_r <= wr_en && paddr == pdb_pkg::ADDR_MANUAL && !pwdata[1];
            if (wr_en && paddr == pdb_pkg::ADDR_MANUAL) begin
                man_act_r <= !pwdata[1];
                man_val_r <= pwdata[0];
            end
        end
    end

    // external motion on a main unit: 1 counts, 0 ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pulse_r <= 1'b0;
        end else begin
            ext_pulse_r <= ext_motion.valid && ext_motion.value &&
                           !ctrl_r[pdb_pkg::CTRL_EXT];
        end
    end

    // light demand and phase events
    assign tgt    = man_act_r ? man_val_r : motion_any;
    assign go_on  = !dis && tgt &&
                    (lc_state_r == pdb_pkg::LC_OFF || man_wr_r);
    assign go_off = !dis && !tgt &&
                    (lc_state_r == pdb_pkg::LC_ON || man_wr_r);
    assign fmt = pdb_pkg::pdb_fmt_type'(go_on ?
                 ctrl_r[pdb_pkg::CTRL_FON +: 2] :
                 ctrl_r[pdb_pkg::CTRL_FOFF +: 2]);

    // light state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_state_r <= pdb_pkg::LC_OFF;
        end else begin
            unique case (lc_state_r)
                pdb_pkg::LC_OFF: if (go_on) begin
                    lc_state_r <= pdb_pkg::LC_ON;
                end
                pdb_pkg::LC_ON: if (go_off) begin
                    lc_state_r <= pdb_pkg::LC_OFF;
                end
            endcase
        end
    end

    // channel outputs per phase data format
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_out  <= 1'b0;
            dim_out <= 4'h0;
            val_out <= 8'h00;
        end else if (go_on || go_off) begin
            case (fmt)
                pdb_pkg::FMT_DIM:   dim_out <= go_on ?
                    levels_r[pdb_pkg::LVL_DIMUP +: 4] :
                    levels_r[pdb_pkg::LVL_DIMDN +: 4];
                pdb_pkg::FMT_VALUE: val_out <= go_on ?
                    levels_r[pdb_pkg::LVL_ONVAL +: 8] :
                    levels_r[pdb_pkg::LVL_OFFVAL +: 8];
                default:            sw_out  <= go_on;
            endcase
        end
    end

    // light state mirror
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            light_on <= 1'b0;
        end else begin
            light_on <= lc_state_r == pdb_pkg::LC_ON;
        end
    end

    // minute prescaler restarts whenever motion or delay is present
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_cnt_r <= '0;
        end else if (!el_on || motion_any || min_tick) begin
            min_cnt_r <= '0;
        end else begin
            min_cnt_r <= min_cnt_r + 1'b1;
        end
    end

    // minutes since last motion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed_r <= 16'h0000;
        end else if (!el_on || motion_any) begin
            elapsed_r <= 16'h0000;
        end else if (min_tick && elapsed_r != pdb_pkg::ELAPSED_MAX) begin
            elapsed_r <= elapsed_r + 1'b1;
        end
    end

    // cyclic send of the counter in whole minutes
    assign cyc_fire = el_on && ctrl_r[pdb_pkg::CTRL_ELACT] &&
                      cyc_pre_r == 31'(MINUTE_CYC - 1) &&
                      cyc_min_r + 1'b1 >= cycle_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_pre_r <= '0;
            cyc_min_r <= 8'h00;
        end else if (!el_on || !ctrl_r[pdb_pkg::CTRL_ELACT]) begin
            cyc_pre_r <= '0;
            cyc_min_r <= 8'h00;
        end else if (cyc_pre_r == 31'(MINUTE_CYC - 1)) begin
            cyc_pre_r <= '0;
            cyc_min_r <= cyc_fire ? 8'h00 : cyc_min_r + 1'b1;
        end else begin
            cyc_pre_r <= cyc_pre_r + 1'b1;
        end
    end

    // extension motion report timer
    assign rep_fire = ctrl_r[pdb_pkg::CTRL_EXT] && motion_det &&
                      rep_cnt_r == '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_cnt_r <= '0;
        end else if (!(ctrl_r[pdb_pkg::CTRL_EXT] && motion_det) ||
                     rep_cnt_r == 31'(REPORT_CYC - 1)) begin
            rep_cnt_r <= '0;
        end else begin
            rep_cnt_r <= rep_cnt_r + 1'b1;
        end
    end

    // pending telegrams, lowest index first; a new set wins over grant
    always_comb begin
        pend_set = 5'h00;
        pend_set[pdb_pkg::OBJ_MOTION]  = rep_fire;
        pend_set[pdb_pkg::OBJ_SWITCH]  = (go_on || go_off) &&
            fmt != pdb_pkg::FMT_DIM && fmt != pdb_pkg::FMT_VALUE;
        pend_set[pdb_pkg::OBJ_DIM]     = (go_on || go_off) &&
            fmt == pdb_pkg::FMT_DIM;
        pend_set[pdb_pkg::OBJ_VALUE]   = (go_on || go_off) &&
            fmt == pdb_pkg::FMT_VALUE;
        pend_set[pdb_pkg::OBJ_ELAPSED] = cyc_fire;
    end
    assign grant = fifo_in_ready ? (pend_r & (~pend_r + 5'h01)) : 5'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 5'h00;
        end else begin
            pend_r <= pend_set | (pend_r & ~grant);
        end
    end

    // telegram payload for the granted object
    always_comb begin
        push_tel.obj  = pdb_pkg::OBJ_ELAPSED;
        push_tel.data = elapsed_r;
        for (int i = 4; i >= 0; i--) begin
            if (pend_r[i]) begin
                push_tel.obj = pdb_pkg::pdb_obj_type'(3'(i));
            end
        end
        unique case (push_tel.obj)
            pdb_pkg::OBJ_MOTION:  push_tel.data = 16'h0001;
            pdb_pkg::OBJ_SWITCH:  push_tel.data = {15'h0000, sw_out};
            pdb_pkg::OBJ_DIM:     push_tel.data = {12'h000, dim_out};
            pdb_pkg::OBJ_VALUE:   push_tel.data = {8'h00, val_out};
            pdb_pkg::OBJ_ELAPSED: push_tel.data = elapsed_r;
        endcase
    end

    pdb_fifo #(
        .W($bits(pdb_pkg::pdb_tel_type)),
        .D(8)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (|pend_r),
        .in_ready  (fifo_in_ready),
        .in_data   (push_tel),
        .out_valid (fifo_out_valid),
        .out_ready (!tx_valid || tx_ready),
        .out_data  (fifo_tel)
    );

    // output register stage toward the bus transmitter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_tel   <= '0;
        end else if (!tx_valid || tx_ready) begin
            tx_valid <= fifo_out_valid;
            tx_tel   <= fifo_tel;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rep_one_a: assert property (tx_valid && tx_tel.obj ==
        pdb_pkg::OBJ_MOTION |-> tx_tel.data == 16'h0001)
        else $error("motion report carries zero");
    rep_ext_a: assert property ($rose(pend_r[pdb_pkg::OBJ_MOTION])
        |-> $past(ctrl_r[pdb_pkg::CTRL_EXT]))
        else $error("motion report outside extension mode");
    eff_dly_a: assert property (wr_en && fac_ok &&
        paddr == pdb_pkg::ADDR_FACTOR |-> ##2
        eff_dly_r == $past(pwdata[7:0], 2) * $past(base_r, 2))
        else $error("effective delay not factor times base");
    fac_gate_a: assert property (wr_en && !fac_ok &&
        paddr == pdb_pkg::ADDR_FACTOR |=> $stable(factor_r))
        else $error("factor written while absent");
    man_on_a: assert property (wr_en &&
        paddr == pdb_pkg::ADDR_MANUAL && pwdata[1:0] == 2'b01 && !dis
        |=> ##2 light_on)
        else $error("manual on ignored");
    man_hold_a: assert property (man_act_r && !man_val_r &&
        !man_wr_r && lc_state_r == pdb_pkg::LC_OFF |=>
        lc_state_r == pdb_pkg::LC_OFF)
        else $error("automatic acted during manual off");
    dis_hold_a: assert property (dis |=> $stable(lc_state_r))
        else $error("light state changed while disabled");
    el_zero_a: assert property (motion_det || delay_run |=>
        elapsed_r == 16'h0000)
        else $error("counter nonzero during motion");
    el_sat_a: assert property (elapsed_r == pdb_pkg::ELAPSED_MAX &&
        el_on && !motion_any |=> elapsed_r == pdb_pkg::ELAPSED_MAX)
        else $error("counter left maximum");
    el_off_a: assert property (!el_on |=> elapsed_r == 16'h0000)
        else $error("counter active while absent");
    el_step_a: assert property (min_tick && elapsed_r !=
        pdb_pkg::ELAPSED_MAX |=> elapsed_r == $past(elapsed_r) + 16'h0001)
        else $error("counter missed a minute");
    el_cyc_a: assert property ($rose(pend_r[pdb_pkg::OBJ_ELAPSED])
        |-> $past(ctrl_r[pdb_pkg::CTRL_ELACT]))
        else $error("counter sent while passive");
    mix_c: cover property (go_on && fmt == pdb_pkg::FMT_SWITCH ##[1:300]
        go_off && fmt == pdb_pkg::FMT_DIM);
    rep_c: cover property (rep_fire);
    full_c: cover property (!fifo_in_ready && |pend_r);
    man_c: cover property (man_wr_r && go_on);
endmodule

// File: sim/pdb_sink.sv
`timescale 1ns/1ns
// bus sender model: takes telegrams, answers every other cycle or stalls
module pdb_sink (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 stall,
    input  wire logic                 tx_valid,
    input  wire pdb_pkg::pdb_tel_type tx_tel,
    output logic                      tx_ready,
    output pdb_pkg::pdb_tel_type      last_tel,
    output logic [7:0]                cnt
);
    // ready toggles so the sender sees slow acceptance; stall holds it low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            last_tel <= '0;
            cnt <= 8'h00;
        end else begin
            tx_ready <= !stall && !tx_ready;
            if (tx_valid && tx_ready) begin
                last_tel <= tx_tel;
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ns
// bench: apb tasks, sender model, light and counter sequences
module tb_top;
    logic                 pclk = 1'b0, presetn = 1'b0, stall = 1'b0, e;
    logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00, val_out, cnt;
    logic [31:0]          pwdata = 32'h0, prdata, v;
    logic                 pready, pslverr, tx_valid, tx_ready;
    logic                 motion_det = 1'b0, delay_run = 1'b0;
    logic                 sw_out, light_on;
    logic [3:0]           dim_out;
    logic [18:0]          on_t [3] = '{19'h1_0001, 19'h2_0009, 19'h3_00ff};
    logic [18:0]          off_t [3] = '{19'h2_0001, 19'h3_0000, 19'h1_0000};
    int                   err_total = 0, checked = 0, cyc = 0;
    pdb_pkg::pdb_ext_type ext_motion = '0;
    pdb_pkg::pdb_tel_type tx_tel, last_tel, t;
    // 50 ns clock
    always #25 pclk = ~pclk;
    pdb_top #(.MINUTE_CYC(20), .REPORT_CYC(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .motion_det(motion_det),
        .delay_run(delay_run), .ext_motion(ext_motion),
        .tx_valid(tx_valid), .tx_tel(tx_tel), .tx_ready(tx_ready),
        .sw_out(sw_out), .dim_out(dim_out), .val_out(val_out),
        .light_on(light_on));
    pdb_sink sink (
        .pclk(pclk), .presetn(presetn), .stall(stall), .tx_valid(tx_valid),
        .tx_tel(tx_tel), .tx_ready(tx_ready), .last_tel(last_tel),
        .cnt(cnt));
    task automatic check(string n, logic [31:0] s, logic [31:0] x);
        checked++;
        if (s !== x) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // wait for the next telegram taken by the sender model
    task automatic tel();
        logic [7:0] c0;
        c0 = cnt;
        repeat (100) if (cnt == c0) @(posedge pclk);
        t = last_tel;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(pdb_pkg::ADDR_LEVELS);
        check("levels", v, 32'h19_00ff);
        rd(pdb_pkg::ADDR_EFFDLY);
        check("effdly rst", v, 32'h1);
        rd(8'h28);
        check("unmapped", {v[30:0], e}, 32'h1);
        rd(pdb_pkg::ADDR_CYCLE);
        check("cycle rst", v, 32'h1);
        wr(pdb_pkg::ADDR_FACTOR, 32'h5);
        rd(pdb_pkg::ADDR_FACTOR);
        check("factor absent", v, 32'h0);
        wr(pdb_pkg::ADDR_CTRL, 32'h6);
        wr(pdb_pkg::ADDR_FACTOR, 32'hff);
        wr(pdb_pkg::ADDR_BASE, 32'hffff);
        rd(pdb_pkg::ADDR_EFFDLY);
        check("effdly", v, 32'hfe_ff01);
        stall <= 1'b1;
        // every on format, off format one step further
        for (int f = 0; f < 3; f++) begin
            wr(pdb_pkg::ADDR_CTRL, 32'((f << 8) | (((f + 1) % 3) << 10)));
            wr(pdb_pkg::ADDR_MANUAL, 32'h1);
            if (f == 0) begin
                repeat (10) @(posedge pclk);
                check("stalled", {24'h0, cnt}, 32'h0);
                stall <= 1'b0;
            end
            tel();
            check("on tel", {13'h0, t}, {13'h0, on_t[f]});
            check("lit", {31'h0, light_on}, 32'h1);
            if (f == 0) check("sw", {31'h0, sw_out}, 32'h1);
            wr(pdb_pkg::ADDR_MANUAL, 32'h0);
            tel();
            check("off tel", {13'h0, t}, {13'h0, off_t[f]});
        end
        check("dim", {28'h0, dim_out}, 32'h9);
        check("val", {24'h0, val_out}, 32'hff);
        rd(pdb_pkg::ADDR_STATUS);
        check("status", v, 32'h2);
        motion_det <= 1'b1;
        repeat (20) @(posedge pclk);
        check("held off", {31'h0, light_on}, 32'h0);
        wr(pdb_pkg::ADDR_MANUAL, 32'h2);
        tel();
        check("auto on", {13'h0, t}, 32'h3_00ff);
        wr(pdb_pkg::ADDR_DISABL, 32'h1);
        rd(pdb_pkg::ADDR_DISABL);
        check("disable", v, 32'h1);
        rd(pdb_pkg::ADDR_STATUS);
        check("disabled", {31'h0, v[3]}, 32'h1);
        wr(pdb_pkg::ADDR_CTRL, 32'h8);
        rd(pdb_pkg::ADDR_STATUS);
        check("inverted", {31'h0, v[3]}, 32'h0);
        wr(pdb_pkg::ADDR_DISABL, 32'h0);
        wr(pdb_pkg::ADDR_CTRL, 32'h30);
        rd(pdb_pkg::ADDR_ELAPSD);
        check("elapsed motion", v, 32'h0);
        delay_run <= 1'b1;
        motion_det <= 1'b0;
        repeat (60) @(posedge pclk);
        rd(pdb_pkg::ADDR_ELAPSD);
        check("elapsed delay", v, 32'h0);
        delay_run <= 1'b0;
        repeat (50) @(posedge pclk);
        rd(pdb_pkg::ADDR_ELAPSD);
        check("elapsed", v, 32'h2);
        // external motion: a zero is ignored, a one flashes the light
        v = {24'h0, cnt};
        ext_motion <= '{1'b1, 1'b0};
        @(posedge pclk);
        ext_motion <= '0;
        repeat (10) @(posedge pclk);
        check("ext zero", {24'h0, cnt}, v);
        ext_motion <= '{1'b1, 1'b1};
        @(posedge pclk);
        ext_motion <= '0;
        tel();
        check("ext on", {13'h0, t}, 32'h1_0001);
        tel();
        check("ext off", {13'h0, t}, 32'h1_0000);
        wr(pdb_pkg::ADDR_CTRL, 32'h70);
        tel();
        check("cyclic", {29'h0, t.obj}, 32'h4);
        wr(pdb_pkg::ADDR_CTRL, 32'h1);
        wr(pdb_pkg::ADDR_DISABL, 32'h1);
        motion_det <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            tel();
            check("report", {13'h0, t}, 32'h1);
        end
        tally_and_finish();
    end
endmodule
